// File: pkg/bsl_pkg.sv
// shared constants for the boot status lamp and general control block
package bsl_pkg;
    // ******************************************************************
    // register map (byte addresses on the apb slave)
    // ******************************************************************
    localparam logic [11:0] BSL_GCR_OFF = 12'h000;
    localparam logic [11:0] BSL_STAT_OFF = 12'h004;

    // ******************************************************************
    // general control register field layout
    // ******************************************************************
    localparam int BSL_OVL_BIT = 3;
    localparam int BSL_CODE_LSB = 8;
    localparam int BSL_CODE_MSB = 12;
    localparam int BSL_EXEC_BIT = 13;
    localparam int BSL_CC_BIT = 14;
    localparam int BSL_ERR_BIT = 15;
    localparam logic [31:0] BSL_GCR_MASK = 32'h0000_ff08;
    localparam logic [31:0] BSL_GCR_RST = 32'h0000_0000;

    // ******************************************************************
    // status register field layout
    // ******************************************************************
    localparam int BSL_STAT_OVL_BIT = 0;
    localparam int BSL_STAT_SEEN_BIT = 1;
    localparam logic BSL_SEEN_RST = 1'b0;

    // ******************************************************************
    // address overlay
    // ******************************************************************
    localparam logic [31:0] BSL_RESET_ADDR = 32'h0000_0000;
    localparam logic [31:0] BSL_ROM_BASE = 32'h8000_0000;
    localparam logic [31:0] BSL_ROM_WINDOW = 32'h0000_0008;
endpackage

// File: hdl/bsl_remap.sv
// address overlay that folds low processor addresses onto the rom base
`timescale 1ns/100ps
`default_nettype none
module bsl_remap
    import bsl_pkg::*;
#(
    parameter logic [31:0] WINDOW = BSL_ROM_WINDOW
) (
    input wire logic rom_overlay_n,
    input wire logic [31:0] addr_in,
    output logic [31:0] addr_out,
    output logic hit
);
    // ******************************************************************
    // remap path
    // ******************************************************************
    // combinational on purpose: a register here would add a cycle to
    // every processor access, not only to the reset fetch
    always_comb begin
        hit = !rom_overlay_n && ((addr_in - BSL_RESET_ADDR) < WINDOW); // R8
        addr_out = hit ? (BSL_ROM_BASE | (addr_in - BSL_RESET_ADDR)) : addr_in; // R8
    end
endmodule
`default_nettype wire

// File: hdl/bsl_gen_ctrl.sv
// general control register with front panel lamps and rom overlay, apb slave
//
// Contract
// [R1] the five code lamps show a five-bit code, msb on the highest lamp and lsb on the lowest.
// [R2] the error flag lamp is lit for an error code and dark for a progress code.
// [R3] the rom execution lamp shows rom versus ram execution in boot and user mode later.
// [R4] the compiled code lamp is lit while the loader runs compiled code and is idle later.
// [R5] a reset clears the general control register so every output is driven low.
// [R6] that clearing lights all lamps, since a low output means a lit lamp.
// [R7] the active-low rom overlay control sits at bit 3 and is asserted after reset.
// [R8] while the overlay is asserted, accesses at address zero go to the rom base.
// [R9] in its first step the processor releases the overlay and darkens all lamps but rom exec.
// [R10] the processor shows code 1f with the error lamp dark once the loader runs.
// [R11] every lamp and control output holds the last written value until a write or reset.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module bsl_gen_ctrl
    import bsl_pkg::*;
#(
    parameter logic [31:0] ROM_WINDOW = BSL_ROM_WINDOW
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_valid,
    output logic [31:0] mapped_addr,
    output logic rom_overlay_n,
    output logic [4:0] code_lamp_n,
    output logic rom_exec_lamp_n,
    output logic compiled_code_lamp_n,
    output logic error_flag_lamp_n
);
    // ******************************************************************
    // apb decode
    // ******************************************************************
    logic setup;
    logic access;
    logic hit_gcr;
    logic hit_stat;
    logic wr_gcr;
    logic wr_stat;
    logic remap_hit;

    // decode in both phases; the master holds address through access
    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        hit_gcr = (paddr == BSL_GCR_OFF);
        hit_stat = (paddr == BSL_STAT_OFF);
        wr_gcr = access && pwrite && hit_gcr;
        wr_stat = access && pwrite && hit_stat;
    end

    // zero wait states: read data and error are latched in the setup cycle
    assign pready = 1'b1;

    // ******************************************************************
    // general control register
    // ******************************************************************
    logic [31:0] gcr_r;
    logic [31:0] gcr_nxt;

    // only lanes 0 and 1 carry defined bits; other bits are not stored
    always_comb begin
        gcr_nxt = gcr_r;
        if (wr_gcr) begin
            if (pstrb[0]) begin
                gcr_nxt[7:0] = pwdata[7:0] & BSL_GCR_MASK[7:0]; // R7
            end
            if (pstrb[1]) begin
                gcr_nxt[15:8] = pwdata[15:8] & BSL_GCR_MASK[15:8]; // R1
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gcr_r <= BSL_GCR_RST; // R5
        end else begin
            gcr_r <= gcr_nxt; // R11
        end
    end

    // outputs follow the register bits directly; low lights a lamp
    always_comb begin
        rom_overlay_n = gcr_r[BSL_OVL_BIT]; // R7
        code_lamp_n = gcr_r[BSL_CODE_MSB:BSL_CODE_LSB]; // R1
        rom_exec_lamp_n = gcr_r[BSL_EXEC_BIT]; // R3
        compiled_code_lamp_n = gcr_r[BSL_CC_BIT]; // R4
        error_flag_lamp_n = gcr_r[BSL_ERR_BIT]; // R2 R6
    end

    // ******************************************************************
    // address overlay and remap tracking
    // ******************************************************************
    bsl_remap #(
        .WINDOW(ROM_WINDOW)
    ) u_remap (
        .rom_overlay_n(rom_overlay_n),
        .addr_in(cpu_addr),
        .addr_out(mapped_addr),
        .hit(remap_hit)
    );

    logic seen_r;
    logic seen_nxt;

    // sticky flag of a remapped access; a new hit wins over a clear
    always_comb begin
        seen_nxt = seen_r;
        if (wr_stat && pstrb[0] && pwdata[BSL_STAT_SEEN_BIT]) begin
            seen_nxt = 1'b0;
        end
        if (cpu_valid && remap_hit) begin
            seen_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            seen_r <= BSL_SEEN_RST;
        end else begin
            seen_r <= seen_nxt;
        end
    end

    // ******************************************************************
    // read data and slave error
    // ******************************************************************
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic err_r;
    logic err_nxt;

    // unmapped addresses answer with pslverr and zero data
    always_comb begin
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        if (setup) begin
            rdata_nxt = 32'h0000_0000;
            err_nxt = !(hit_gcr || hit_stat);
            if (hit_gcr) begin
                rdata_nxt = gcr_r;
            end
            if (hit_stat) begin
                rdata_nxt[BSL_STAT_OVL_BIT] = !rom_overlay_n;
                rdata_nxt[BSL_STAT_SEEN_BIT] = seen_r;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end

    assign prdata = rdata_r;
    assign pslverr = access && err_r;

    // ******************************************************************
    // checks
    // ******************************************************************
    logic up_r;

    // marks the first cycle after reset release
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            up_r <= 1'b0;
        end else begin
            up_r <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    reset_low_a: assert property (!up_r |-> (gcr_r == 32'h0000_0000) && !rom_overlay_n) // R5
        else $error("outputs not low after reset");
    lamps_lit_a: assert property (!up_r |-> (code_lamp_n == 5'h00) && !error_flag_lamp_n
            && !rom_exec_lamp_n && !compiled_code_lamp_n) // R6
        else $error("lamps not lit after reset");
    code_lamp_a: assert property (wr_gcr && pstrb[1]
            |=> code_lamp_n == $past(pwdata[BSL_CODE_MSB:BSL_CODE_LSB])) // R1
        else $error("code lamps do not follow write");
    err_lamp_a: assert property (wr_gcr && pstrb[1]
            |=> error_flag_lamp_n == $past(pwdata[BSL_ERR_BIT])) // R2
        else $error("error lamp does not follow write");
    exec_lamp_a: assert property (wr_gcr && pstrb[1]
            |=> rom_exec_lamp_n == $past(pwdata[BSL_EXEC_BIT])) // R3
        else $error("rom exec lamp does not follow write");
    cc_lamp_a: assert property (wr_gcr && pstrb[1]
            |=> compiled_code_lamp_n == $past(pwdata[BSL_CC_BIT])) // R4
        else $error("compiled code lamp does not follow write");
    overlay_bit_a: assert property (wr_gcr && pstrb[0]
            |=> rom_overlay_n == $past(pwdata[BSL_OVL_BIT])) // R7
        else $error("overlay does not follow bit 3");
    hold_out_a: assert property (!wr_gcr |=> $stable({rom_overlay_n, code_lamp_n,
            rom_exec_lamp_n, compiled_code_lamp_n, error_flag_lamp_n})) // R11
        else $error("outputs changed without a write");
    remap_zero_a: assert property (!rom_overlay_n && (cpu_addr == BSL_RESET_ADDR)
            |-> mapped_addr == BSL_ROM_BASE) // R8
        else $error("reset address not mapped to rom base");
    remap_off_a: assert property (rom_overlay_n |-> mapped_addr == cpu_addr) // R8
        else $error("address remapped with overlay released");
    seen_wins_a: assert property (cpu_valid && remap_hit |=> seen_r)
        else $error("remap hit lost");
endmodule
`default_nettype wire

// File: tb/bsl_cpu_model.sv
// processor side model that issues fetch addresses toward the overlay
`timescale 1ns/100ps
`default_nettype none
module bsl_cpu_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [31:0] req_addr,
    input wire logic req_valid,
    output logic [31:0] cpu_addr,
    output logic cpu_valid
);
    // between fetches the bus flips every cycle so a stale address never looks held
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_addr <= 32'h5555_aaaa;
            cpu_valid <= 1'b0;
        end else begin
            cpu_addr <= req_valid ? req_addr : ~cpu_addr;
            cpu_valid <= req_valid;
        end
    end
endmodule
`default_nettype wire

// File: tb/boot_status_led_control_tb.sv
// self-checking bench for the boot status lamp and general control block
`timescale 1ns/100ps
`default_nettype none
module boot_status_led_control_tb import bsl_pkg::*;;
    logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic req_valid = 1'b0, cpu_valid, pready, pslverr, rom_overlay_n, er;
    logic rom_exec_lamp_n, compiled_code_lamp_n, error_flag_lamp_n;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, req_addr = 32'h0, cpu_addr, prdata, mapped_addr, rd;
    logic [3:0] pstrb = 4'h0;
    logic [4:0] code_lamp_n;
    int bad_count = 0, check_count = 0;
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    bsl_gen_ctrl dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .cpu_addr, .cpu_valid, .mapped_addr, .rom_overlay_n,
        .code_lamp_n, .rom_exec_lamp_n, .compiled_code_lamp_n, .error_flag_lamp_n);
    bsl_cpu_model cpu (.core_clk, .rstn, .req_addr, .req_valid, .cpu_addr, .cpu_valid);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // lamp and overlay pins against the raw register image they should mirror
    task automatic lamps(input logic [31:0] g, input string msg);
        chk({23'h0, error_flag_lamp_n, compiled_code_lamp_n, rom_exec_lamp_n, code_lamp_n,
            rom_overlay_n}, {23'h0, g[BSL_ERR_BIT:BSL_CODE_LSB], g[BSL_OVL_BIT]}, msg);
    endtask
    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        // no local limit: only the watchdog may end a wait for the slave
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic fetch(input logic [31:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        req_addr <= a;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        #1 chk(mapped_addr, exp, "mapped address");
    endtask
    // ******************************************************************
    // scenarios
    // ******************************************************************
    task automatic t_reset;
        lamps(32'h0, "reset lamps");
        apb(1'b0, BSL_GCR_OFF, 32'h0, 4'h0);
        chk(rd, 32'h0, "reset gcr");
        $display("test reset done");
    endtask
    task automatic t_remap;
        fetch(32'h0, 32'h8000_0000);
        fetch(32'h4, 32'h8000_0004);
        fetch(32'h8, 32'h8);
        apb(1'b0, BSL_STAT_OFF, 32'h0, 4'h0);
        chk({30'h0, rd[1:0]}, 32'h3, "overlay status");
        chk({31'h0, er}, 32'h0, "mapped read error");
        apb(1'b1, BSL_STAT_OFF, 32'h2, 4'h1);
        apb(1'b0, BSL_STAT_OFF, 32'h0, 4'h0);
        chk({30'h0, rd[1:0]}, 32'h1, "seen flag cleared");
        $display("test remap done");
    endtask
    // first boot step: overlay released, only the rom lamp left lit
    task automatic t_boot;
        apb(1'b1, BSL_GCR_OFF, 32'h0000_df08, 4'hf);
        lamps(32'h0000_df08, "boot step");
        fetch(32'h0, 32'h0);
        repeat (6) @(posedge core_clk);
        #1 lamps(32'h0000_df08, "held");
        apb(1'b0, BSL_GCR_OFF, 32'h0, 4'h0);
        chk(rd, 32'h0000_df08, "gcr read");
        $display("test boot done");
    endtask
    // each code bit alone, then the finished code with the error lamp dark
    task automatic t_codes;
        logic [31:0] g;
        for (int i = 0; i < 5; i++) begin
            g = {16'h0, 3'b001, ~(5'h01 << i), 8'h08};
            apb(1'b1, BSL_GCR_OFF, g, 4'hf);
            lamps(g, "code bit");
        end
        apb(1'b1, BSL_GCR_OFF, 32'h0000_a008, 4'hf);
        lamps(32'h0000_a008, "loader running");
        $display("test codes done");
    endtask
    task automatic t_refuse;
        apb(1'b1, 12'h010, 32'h0, 4'hf);
        chk({31'h0, er}, 32'h1, "unmapped error");
        lamps(32'h0000_a008, "unmapped write");
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        chk(rd, 32'h0, "unmapped read data");
        chk({31'h0, er}, 32'h1, "unmapped read error");
        apb(1'b1, BSL_GCR_OFF, 32'h0, 4'h2);
        lamps(32'h0000_0008, "lane one only");
        $display("test refuse done");
    endtask
    // a reset in mid-run must bring back the overlay and every lit lamp
    task automatic t_midreset;
        @(posedge core_clk);
        rstn <= 1'b0;
        #1 lamps(32'h0, "mid reset");
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        fetch(32'h0, 32'h8000_0000);
        $display("test midreset done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_remap();
        t_boot();
        t_codes();
        t_refuse();
        t_midreset();
        end_of_test();
    end
    // the whole run needs some 70 cycles, so this limit only trips on a hang
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
